// [design/eeprom_wp_pkg.sv]
// constants, modes and carriers shared by the write-protection logic
package eeprom_wp_pkg;
  // slave address preambles, upper nibble
  localparam logic [3:0] MEM_PREAMBLE = 4'ha;
  localparam logic [3:0] PROT_PREAMBLE = 4'h6;
  // select bits expected for reversible-flag commands
  localparam logic [2:0] SEL_SET_R = 3'h1;
  localparam logic [2:0] SEL_CLR_R = 3'h3;
  // select pins two and one levels required with those commands
  localparam logic [1:0] PINS_SET_R = 2'h0;
  localparam logic [1:0] PINS_CLR_R = 2'h1;
  // bits per byte before the acknowledge slot
  localparam logic [3:0] BYTE_BITS = 4'h8;
  // byte index: slave address, byte address, data
  localparam logic [1:0] IDX_SLAVE = 2'h0;
  localparam logic [1:0] IDX_ADDR = 2'h1;
  localparam logic [1:0] IDX_DATA = 2'h2;
  // internal nonvolatile write time, and the clock rate
  localparam int TWR_US = 5000;
  localparam int MCLK_MHZ = 10;
  localparam int BUSY_W = 17;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RX = 2'b01,
    ST_ACK = 2'b10
  } bus_state_t;

  typedef enum logic [1:0] {
    OP_NONE = 2'b00,
    OP_SET_P = 2'b01,
    OP_SET_R = 2'b10,
    OP_CLR_R = 2'b11
  } prot_op_t;

  typedef struct packed {
    logic scl;
    logic sda;
    logic wp;
    logic overdrive;
    logic [2:0] sel;
  } pin_in_t;

  typedef struct packed {
    logic wr;
    logic [7:0] addr;
    logic [7:0] data;
  } mem_wr_t;

  typedef struct packed {
    logic oe;
    logic out;
  } sda_drive_t;
endpackage

// [design/eeprom_write_protect_logic.sv]
// two-wire slave front end with software and hardware write protection
// Summary of operation
// - lower 128 bytes refuse writes when flagged
// - permanent flag reachable at plain pin levels
// - reversible flag commands need overdrive on pin zero
// - preamble 0110 protection, 1010 memory
// - permanent commands match address bits to pins
// - overdrive on pin zero counts as one
// - overdrive latched at start; absent means permanent
// - address lsb one queries, zero sets/clears
// - query answers by ack, no data byte
// - write-protect pin high blocks array and flags
// - write-protect pin low changes nothing
// - write-protect sampled on fall before data
// - sampled high withholds data ack, drops write
// - write cycle starts on the terminating stop
// - busy write cycle refuses slave address
`timescale 1ns/1ps
module eeprom_write_protect_logic #(
  parameter int WR_CYCLE_CYC = eeprom_wp_pkg::TWR_US * eeprom_wp_pkg::MCLK_MHZ
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic srst_i,
  // two-wire bus
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  // address, overdrive and write-protect pins
  input wire logic select_pin_zero_i,
  input wire logic select_pin_one_i,
  input wire logic select_pin_two_i,
  input wire logic overdrive_level_i,
  input wire logic wp_i,
  // protection state and array write port
  output logic permanent_protect_flag_o,
  output logic reversible_protect_flag_o,
  output logic write_busy_o,
  output eeprom_wp_pkg::mem_wr_t mem_wr_o
);

  typedef struct packed {
    eeprom_wp_pkg::pin_in_t s1;
    eeprom_wp_pkg::pin_in_t s2;
    logic scl_d;
    logic sda_d;
    eeprom_wp_pkg::bus_state_t st;
    logic [3:0] bitcnt;
    logic [7:0] shreg;
    logic [1:0] byte_idx;
    logic is_prot;
    logic is_rw;
    logic hv_lat;
    logic wp_lat;
    logic ack;
    eeprom_wp_pkg::prot_op_t op;
    logic pend;
    logic [7:0] addr;
    logic [eeprom_wp_pkg::BUSY_W-1:0] busy_cnt;
    logic busy;
    logic pflag;
    logic rflag;
    eeprom_wp_pkg::mem_wr_t mw;
    eeprom_wp_pkg::sda_drive_t sda;
  } state_t;

  state_t r;
  state_t n;
  eeprom_wp_pkg::pin_in_t pins;
  logic scl_rise;
  logic scl_fall;
  logic start_ev;
  logic stop_ev;
  logic decide;
  logic [2:0] sel_bits;
  logic sel_match;
  logic rev_set;
  logic rev_clr;

  // last count of the write cycle, cut to the counter width on purpose
  localparam logic [31:0] BUSY_LAST_W = 32'(WR_CYCLE_CYC - 1);
  localparam logic [eeprom_wp_pkg::BUSY_W-1:0] BUSY_LAST = BUSY_LAST_W[eeprom_wp_pkg::BUSY_W-1:0];

  assign pins = '{scl: scl_i, sda: sda_i, wp: wp_i, overdrive: overdrive_level_i,
                  sel: {select_pin_two_i, select_pin_one_i, select_pin_zero_i}};

  // bus events look only at the second synchroniser stage and its delayed copy
  assign scl_rise = r.s2.scl & ~r.scl_d;
  assign scl_fall = ~r.s2.scl & r.scl_d;
  assign start_ev = r.s2.scl & r.scl_d & r.sda_d & ~r.s2.sda;
  assign stop_ev = r.s2.scl & r.scl_d & ~r.sda_d & r.s2.sda;
  assign decide = (r.st == eeprom_wp_pkg::ST_RX) && (r.bitcnt == eeprom_wp_pkg::BYTE_BITS) && scl_fall;

  // overdrive reads as a one on pin zero
  assign sel_bits = {r.s2.sel[2], r.s2.sel[1], r.s2.sel[0] | r.s2.overdrive};
  assign sel_match = (r.shreg[3:1] == sel_bits);
  // reversible commands need fixed select bits and matching pin levels
  assign rev_set = (r.shreg[3:1] == eeprom_wp_pkg::SEL_SET_R) && (r.s2.sel[2:1] == eeprom_wp_pkg::PINS_SET_R);
  assign rev_clr = (r.shreg[3:1] == eeprom_wp_pkg::SEL_CLR_R) && (r.s2.sel[2:1] == eeprom_wp_pkg::PINS_CLR_R);

  always_comb begin
    n = r;
    n.s1 = pins;
    n.s2 = r.s1;
    n.scl_d = r.s2.scl;
    n.sda_d = r.s2.sda;
    n.mw.wr = 1'b0;
    n.sda.out = 1'b0;
    if (r.busy) begin
      if (r.busy_cnt == BUSY_LAST) begin
        n.busy = 1'b0;
      end else begin
        n.busy_cnt = r.busy_cnt + 1'b1;
      end
    end
    if (start_ev) begin
      n.st = eeprom_wp_pkg::ST_RX;
      n.bitcnt = 4'h0;
      n.byte_idx = eeprom_wp_pkg::IDX_SLAVE;
      // overdrive must already stand at start, else the request is permanent
      n.hv_lat = r.s2.overdrive;
      n.pend = 1'b0;
      n.op = eeprom_wp_pkg::OP_NONE;
      n.sda.oe = 1'b0;
    end else if (stop_ev) begin
      // the nonvolatile cycle begins only on stop after an accepted write
      if (r.pend && !r.busy) begin
        n.busy = 1'b1;
        n.busy_cnt = '0;
        case (r.op)
          eeprom_wp_pkg::OP_SET_P: n.pflag = 1'b1;
          eeprom_wp_pkg::OP_SET_R: n.rflag = 1'b1;
          eeprom_wp_pkg::OP_CLR_R: n.rflag = 1'b0;
          default: n.pflag = r.pflag;
        endcase
      end
      n.pend = 1'b0;
      n.st = eeprom_wp_pkg::ST_IDLE;
      n.sda.oe = 1'b0;
    end else begin
      case (r.st)
        eeprom_wp_pkg::ST_RX: begin
          if (scl_rise && r.bitcnt != eeprom_wp_pkg::BYTE_BITS) begin
            n.shreg = {r.shreg[6:0], r.s2.sda};
            n.bitcnt = r.bitcnt + 1'b1;
          end
          if (decide) begin
            n.st = eeprom_wp_pkg::ST_ACK;
            if (r.byte_idx == eeprom_wp_pkg::IDX_SLAVE) begin
              n.is_rw = r.shreg[0];
              n.is_prot = (r.shreg[7:4] == eeprom_wp_pkg::PROT_PREAMBLE);
              if (n.is_prot && r.hv_lat) begin
                // reversible flag reached only under overdrive
                n.op = rev_set ? eeprom_wp_pkg::OP_SET_R : eeprom_wp_pkg::OP_CLR_R;
                // permanent flag locks all reversible commands; repeat set refused
                n.ack = (rev_set || rev_clr) && !r.busy && !r.pflag && !(rev_set && r.rflag);
              end else begin
                // plain pin levels reach the permanent flag
                n.op = n.is_prot ? eeprom_wp_pkg::OP_SET_P : eeprom_wp_pkg::OP_NONE;
                // busy write cycle leaves every address unanswered
                n.ack = sel_match && !r.busy &&
                        ((r.shreg[7:4] == eeprom_wp_pkg::MEM_PREAMBLE) || (n.is_prot && !r.pflag));
              end
            end else if (r.byte_idx == eeprom_wp_pkg::IDX_ADDR) begin
              n.ack = 1'b1;
              n.addr = r.shreg;
            end else begin
              // latched pin high: data unanswered and the write dropped
              n.ack = !r.wp_lat;
              if (!r.wp_lat && !r.is_rw) begin
                if (r.is_prot) begin
                  n.pend = 1'b1;
                end else if (r.addr[7] || !(r.pflag || r.rflag)) begin
                  // lower half is addr bit 7 clear
                  n.mw = '{wr: 1'b1, addr: r.addr, data: r.shreg};
                  n.pend = 1'b1;
                end
                // page write wraps inside the 16-byte page
                n.addr = {r.addr[7:4], r.addr[3:0] + 4'h1};
              end
            end
            n.sda.oe = n.ack;
          end
        end
        eeprom_wp_pkg::ST_ACK: begin
          if (scl_fall) begin
            n.sda.oe = 1'b0;
            n.bitcnt = 4'h0;
            // this fall is the last one before the first data byte
            if (r.byte_idx == eeprom_wp_pkg::IDX_ADDR) begin
              n.wp_lat = r.s2.wp;
            end
            if (r.byte_idx != eeprom_wp_pkg::IDX_DATA) begin
              n.byte_idx = r.byte_idx + 2'h1;
            end
            // a query ends after its ack slot, no data byte follows
            if (r.ack && !(r.byte_idx == eeprom_wp_pkg::IDX_SLAVE && r.is_rw)) begin
              n.st = eeprom_wp_pkg::ST_RX;
            end else begin
              n.st = eeprom_wp_pkg::ST_IDLE;
            end
          end
        end
        default: n.st = eeprom_wp_pkg::ST_IDLE;
      endcase
    end
  end

  // flags reset clear: the nonvolatile copy is modelled as shipped unprotected
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign sda_o = r.sda.out;
  assign sda_oe_o = r.sda.oe;
  assign permanent_protect_flag_o = r.pflag;
  assign reversible_protect_flag_o = r.rflag;
  assign write_busy_o = r.busy;
  assign mem_wr_o = r.mw;

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (srst_i);

  busy_noack_a: assert property (decide && r.byte_idx == eeprom_wp_pkg::IDX_SLAVE && r.busy
    |=> !sda_oe_o) else $error("slave address answered during write cycle");
  perm_lock_a: assert property (decide && r.byte_idx == eeprom_wp_pkg::IDX_SLAVE && r.pflag
    && r.shreg[7:4] == eeprom_wp_pkg::PROT_PREAMBLE |=> !sda_oe_o) else $error("protection command answered while locked");
  wp_data_a: assert property (decide && r.byte_idx == eeprom_wp_pkg::IDX_DATA && r.wp_lat
    |=> !sda_oe_o && !mem_wr_o.wr) else $error("data answered under write protect");
  low_half_a: assert property (mem_wr_o.wr |-> mem_wr_o.addr[7] ||
    !(permanent_protect_flag_o || reversible_protect_flag_o)) else $error("write into protected lower half");
  flag_wp_a: assert property ($changed({r.pflag, r.rflag}) |-> !r.wp_lat && $rose(r.busy))
    else $error("flag changed under write protect or without write cycle");
  stop_cycle_a: assert property (stop_ev && r.pend && !r.busy |=> write_busy_o
    ##1 write_busy_o[*8]) else $error("write cycle not started on stop");
  query_end_a: assert property (r.st == eeprom_wp_pkg::ST_ACK && scl_fall && !start_ev && !stop_ev
    && r.byte_idx == eeprom_wp_pkg::IDX_SLAVE && r.is_rw && r.is_prot |=> r.st == eeprom_wp_pkg::ST_IDLE && !sda_oe_o)
    else $error("query returned more than its ack slot");
  no_hv_perm_a: assert property (decide && r.byte_idx == eeprom_wp_pkg::IDX_SLAVE && !r.hv_lat
    && r.shreg[7:4] == eeprom_wp_pkg::PROT_PREAMBLE |=> r.op == eeprom_wp_pkg::OP_SET_P)
    else $error("protection request without overdrive not taken as permanent");
  ack_slot_a: assert property (sda_oe_o |-> r.st == eeprom_wp_pkg::ST_ACK)
    else $error("sda driven outside an ack slot");
  hold_busy_a: assert property ($rose(write_busy_o) |-> !$past(r.busy) && $past(stop_ev))
    else $error("write cycle started without stop");

  // slave address decision, one branch each
  pre_bad_a: assert property (decide && r.byte_idx == eeprom_wp_pkg::IDX_SLAVE
    && r.shreg[7:4] != eeprom_wp_pkg::PROT_PREAMBLE && r.shreg[7:4] != eeprom_wp_pkg::MEM_PREAMBLE |=> !sda_oe_o)
    else $error("foreign preamble answered");
  sel_miss_a: assert property (decide && r.byte_idx == eeprom_wp_pkg::IDX_SLAVE && !sel_match
    && !(r.hv_lat && r.shreg[7:4] == eeprom_wp_pkg::PROT_PREAMBLE) |=> !sda_oe_o)
    else $error("address answered with select mismatch");
  perm_ack_a: assert property (decide && r.byte_idx == eeprom_wp_pkg::IDX_SLAVE && !r.hv_lat
    && sel_match && !r.busy && !r.pflag && r.shreg[7:4] == eeprom_wp_pkg::PROT_PREAMBLE |=> sda_oe_o)
    else $error("permanent flag command refused at plain levels");
  od_one_a: assert property (decide && r.byte_idx == eeprom_wp_pkg::IDX_SLAVE && r.s2.overdrive
    && r.shreg[1] && r.shreg[3:2] == r.s2.sel[2:1] && r.shreg[7:4] == eeprom_wp_pkg::MEM_PREAMBLE && !r.busy
    |=> sda_oe_o) else $error("overdrive not taken as a one on pin zero");
  rev_bad_a: assert property (decide && r.byte_idx == eeprom_wp_pkg::IDX_SLAVE && r.hv_lat
    && r.shreg[7:4] == eeprom_wp_pkg::PROT_PREAMBLE && !rev_set && !rev_clr |=> !sda_oe_o)
    else $error("reversible command answered at wrong select levels");
  rev_ack_a: assert property (decide && r.byte_idx == eeprom_wp_pkg::IDX_SLAVE && r.hv_lat && rev_clr
    && r.shreg[7:4] == eeprom_wp_pkg::PROT_PREAMBLE && !r.busy && !r.pflag |=> sda_oe_o)
    else $error("reversible clear refused under overdrive");
  rev_dup_a: assert property (decide && r.byte_idx == eeprom_wp_pkg::IDX_SLAVE && r.hv_lat && rev_set
    && r.shreg[7:4] == eeprom_wp_pkg::PROT_PREAMBLE && r.rflag |=> !sda_oe_o)
    else $error("reversible set answered while already set");

  // byte stages and the write-protect strobe
  addr_ack_a: assert property (decide
    && r.byte_idx == eeprom_wp_pkg::IDX_ADDR |=> sda_oe_o)
    else $error("byte address refused");
  data_ack_a: assert property (decide && r.byte_idx == eeprom_wp_pkg::IDX_DATA && !r.wp_lat
    |=> sda_oe_o)
    else $error("data refused with write protect low");
  wp_pend_a: assert property (decide && r.byte_idx == eeprom_wp_pkg::IDX_DATA && r.wp_lat
    |=> !r.pend)
    else $error("write cycle armed under write protect");
  wp_strobe_a: assert property (r.st == eeprom_wp_pkg::ST_ACK && scl_fall
    && r.byte_idx == eeprom_wp_pkg::IDX_ADDR |=> r.wp_lat == $past(r.s2.wp))
    else $error("write protect not strobed before the data byte");

  // framing and the write cycle
  start_clr_a: assert property (start_ev
    |=> r.st == eeprom_wp_pkg::ST_RX && r.bitcnt == 4'h0 && !sda_oe_o)
    else $error("start did not open a fresh frame");
  od_latch_a: assert property (start_ev
    |=> r.hv_lat == $past(r.s2.overdrive))
    else $error("overdrive not latched at start");
  stop_idle_a: assert property (stop_ev
    |=> r.st == eeprom_wp_pkg::ST_IDLE && !r.pend && !sda_oe_o)
    else $error("stop did not close the frame");
  flag_stop_a: assert property ($changed({r.pflag, r.rflag})
    |-> $past(stop_ev))
    else $error("flag changed away from a stop");
  busy_len_a: assert property ($fell(write_busy_o)
    |-> $past(r.busy_cnt) == BUSY_LAST)
    else $error("write cycle ended early");
endmodule

// [tb/i2c_master_model.sv]
// two-wire bus master model: clock, start, stop and bytes
`timescale 1ns/1ps
module i2c_master_model (
  // system clock, used only to pace the bus
  input wire logic mclk_i,
  // bus
  output logic scl_o,
  output logic sda_low_o,
  input wire logic sda_i
);
  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end
  // a quarter of the 800 ns bus period; bus stands still between frames
  task automatic q();
    repeat (2) @(posedge mclk_i);
    #1;
  endtask
  task automatic start();
    q();
    sda_low_o = 1'b1;
    q();
    scl_o = 1'b0;
    q();
  endtask
  // low phase is four system clocks, one more than the slave needs to answer
  task automatic bit_x(input logic b, output logic s);
    sda_low_o = ~b;
    q();
    scl_o = 1'b1;
    q();
    s = sda_i;
    q();
    scl_o = 1'b0;
    q();
  endtask
  task automatic wbyte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_x(b[i], s);
    end
    bit_x(1'b1, s);
    ack = ~s;
  endtask
  task automatic stop();
    sda_low_o = 1'b1;
    q();
    scl_o = 1'b1;
    q();
    sda_low_o = 1'b0;
    q();
  endtask
endmodule

// [tb/tb_eeprom_write_protect_logic.sv]
// bench for the write-protection front end
`timescale 1ns/1ps
module tb_eeprom_write_protect_logic;
  logic mclk_i = 1'b0;
  logic srst_i = 1'b1;
  logic scl, sda_low, sda_w, sda_o, sda_oe_o, wp_i, od, pflag, rflag, busy;
  logic [2:0] pins;
  logic [7:0] rd, ra;
  logic p_exp = 1'b0;
  logic r_exp = 1'b0;
  eeprom_wp_pkg::mem_wr_t mem_wr;
  int n_fail = 0;
  int comparisons = 0;
  int n_wr = 0;
  integer seed = 32'h3b222e20;
  always #50 mclk_i = ~mclk_i;
  // pull-up wire: low if either side pulls
  assign sda_w = ~(sda_low | sda_oe_o);
  i2c_master_model m (.mclk_i(mclk_i), .scl_o(scl), .sda_low_o(sda_low), .sda_i(sda_w));
  eeprom_write_protect_logic #(.WR_CYCLE_CYC(200)) dut (.mclk_i(mclk_i), .srst_i(srst_i), .scl_i(scl),
    .sda_i(sda_w), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .select_pin_zero_i(pins[0]),
    .select_pin_one_i(pins[1]), .select_pin_two_i(pins[2]), .overdrive_level_i(od), .wp_i(wp_i),
    .permanent_protect_flag_o(pflag), .reversible_protect_flag_o(rflag), .write_busy_o(busy),
    .mem_wr_o(mem_wr));
  // sampled away from the launching edge so the one-cycle pulse is seen once
  always @(negedge mclk_i) begin
    if (mem_wr.wr === 1'b1) begin
      n_wr = n_wr + 1;
      rd = mem_wr.data;
      ra = mem_wr.addr;
    end
  end
  task automatic print_verdict();
    $display("checks %0d, mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  function automatic logic stores(input logic [7:0] a, input logic w);
    return !w && !(!a[7] && (p_exp || r_exp));
  endfunction
  // exp: expected acks of slave address, byte address, data
  task automatic frame(input logic [7:0] sa, input logic [7:0] a, input logic [7:0] d, input logic [2:0] exp);
    logic k;
    m.start();
    m.wbyte(sa, k);
    chk("slave ack", 16'(k), 16'(exp[2]));
    if (k && !sa[0]) begin
      m.wbyte(a, k);
      chk("addr ack", 16'(k), 16'(exp[1]));
      m.wbyte(d, k);
      chk("data ack", 16'(k), 16'(exp[0]));
    end
    m.stop();
  endtask
  task automatic settle(input logic b);
    repeat (4) @(posedge mclk_i);
    #1;
    chk("busy", 16'(busy), 16'(b));
    chk("sda out", 16'(sda_o), 16'h0);
    for (int i = 0; i < 400 && busy !== 1'b0; i++) @(posedge mclk_i);
    #1;
    chk("flags", 16'({pflag, rflag}), 16'({p_exp, r_exp}));
  endtask
  task automatic mw(input logic [7:0] a, input logic poll);
    logic [7:0] d;
    int w0;
    logic s;
    d = 8'($random(seed));
    w0 = n_wr;
    s = stores(a, wp_i);
    frame({4'ha, pins, 1'b0}, a, d, {2'b11, ~wp_i});
    if (poll) frame({4'ha, pins, 1'b0}, a, d, 3'b000);
    settle(s);
    chk("stored", 16'(n_wr - w0), 16'(s));
    if (s) chk("array write", {ra, rd}, {a, d});
  endtask
  initial begin
    wp_i = 1'b0;
    od = 1'b0;
    pins = 3'h0;
    repeat (4) @(posedge mclk_i);
    #1 srst_i = 1'b0;
    repeat (6) @(posedge mclk_i);
    #1 pins = 3'($random(seed));
    frame({4'h6, pins, 1'b1}, 8'h0, 8'h0, 3'b100);
    frame({4'h5, pins, 1'b0}, 8'h0, 8'h0, 3'b000);
    frame({4'ha, ~pins, 1'b0}, 8'h0, 8'h0, 3'b000);
    mw({1'b0, 7'($random(seed))}, 1'b1);
    wp_i = 1'b1;
    mw(8'h90, 1'b0);
    frame({4'h6, pins, 1'b0}, 8'h0, 8'h0, 3'b110);
    settle(1'b0);
    wp_i = 1'b0;
    od = 1'b1;
    pins = 3'h0;
    frame(8'h62, 8'($random(seed)), 8'($random(seed)), 3'b111);
    r_exp = 1'b1;
    settle(1'b1);
    frame(8'h62, 8'h0, 8'h0, 3'b000);
    settle(1'b0);
    frame(8'h63, 8'h0, 8'h0, 3'b000);
    frame(8'ha3, 8'h0, 8'h0, 3'b100);
    frame(8'h66, 8'h0, 8'h0, 3'b000);
    od = 1'b0;
    pins = 3'($random(seed));
    mw({1'b0, 7'($random(seed))}, 1'b0);
    mw({1'b1, 7'($random(seed))}, 1'b0);
    od = 1'b1;
    pins = 3'h2;
    frame(8'h66, 8'h0, 8'h0, 3'b111);
    r_exp = 1'b0;
    settle(1'b1);
    od = 1'b0;
    pins = 3'($random(seed));
    frame({4'h6, pins, 1'b0}, 8'h0, 8'h0, 3'b111);
    p_exp = 1'b1;
    settle(1'b1);
    frame({4'h6, pins, 1'b1}, 8'h0, 8'h0, 3'b000);
    mw({1'b0, 7'($random(seed))}, 1'b0);
    od = 1'b1;
    pins = 3'h0;
    frame(8'h62, 8'h0, 8'h0, 3'b000);
    settle(1'b0);
    print_verdict();
  end
  initial begin
    #3000000;
    n_fail++;
    print_verdict();
  end
endmodule
